/* File: hw/srb_bit_engine.sv */
// Single-bit engine on a byte operand, purely combinational.
// Assumes the top has resolved the bit index and rejected illegal index sources.
`timescale 1ns/1ps
`default_nettype none
`include "srb_params.svh"
module srb_bit_engine (
  srb_op_if.bit_eng bus
);
  logic [7:0] sel;
  logic       b;
  logic       cond_ok;

  always_comb begin
    sel        = 8'h01 << bus.idx;
    b          = bus.operand[bus.idx];
    cond_ok    = (bus.zin == bus.cond_z);
    bus.bo_res = bus.operand[7:0];
    bus.bo_wr  = 1'h0;
    bus.bo_c   = bus.cin;
    bus.bo_z   = bus.zin;
    case (bus.op)
      srb_pkg::OP_BIT_SET: begin
        bus.bo_res = bus.operand[7:0] | sel;
        bus.bo_wr  = 1'h1;
      end
      // A false condition hands back the byte as it was, so the result is never stale.
      srb_pkg::OP_CONDITIONAL_BIT_SET: begin
        bus.bo_res = cond_ok ? (bus.operand[7:0] | sel) : bus.operand[7:0];
        bus.bo_wr  = cond_ok;
      end
      srb_pkg::OP_BIT_CLEAR: begin
        bus.bo_res = bus.operand[7:0] & ~sel;
        bus.bo_wr  = 1'h1;
      end
      srb_pkg::OP_CONDITIONAL_BIT_CLEAR: begin
        bus.bo_res = cond_ok ? (bus.operand[7:0] & ~sel) : bus.operand[7:0];
        bus.bo_wr  = cond_ok;
      end
      srb_pkg::OP_BIT_INVERT: begin
        bus.bo_res = bus.operand[7:0] ^ sel;
        bus.bo_wr  = 1'h1;
      end
      srb_pkg::OP_BIT_TEST: begin
        bus.bo_z = ~b;
      end
      srb_pkg::OP_CARRY_AND_BIT: begin
        bus.bo_c = bus.cin & b;
      end
      srb_pkg::OP_CARRY_AND_INVERSE_BIT: begin
        bus.bo_c = bus.cin & ~b;
      end
      default: begin
        bus.bo_wr = 1'h0;
      end
    endcase
  end
endmodule
`default_nettype wire

/* File: hw/srb_op_if.sv */
// Carrier between the unit's top and its shift and bit engines.
// Assumes all three parties sit on one clock; the engines are combinational.
`timescale 1ns/1ps
`default_nettype none
`include "srb_params.svh"
interface srb_op_if;
  srb_pkg::srb_op_e        op;
  srb_pkg::srb_size_e      size;
  srb_pkg::srb_data_t      operand;
  logic [`SRB_AMT_W-1:0]   amt;
  logic [`SRB_IDX_W-1:0]   idx;
  logic                    cin;
  logic                    zin;
  logic                    cond_z;
  srb_pkg::srb_data_t      sh_res;
  logic                    sh_c;
  logic [7:0]              bo_res;
  logic                    bo_wr;
  logic                    bo_c;
  logic                    bo_z;

  modport top (output op, size, operand, amt, idx, cin, zin, cond_z,
               input sh_res, sh_c, bo_res, bo_wr, bo_c, bo_z);
  modport shf (input op, size, operand, amt, cin, output sh_res, sh_c);
  modport bit_eng (input op, operand, idx, cin, zin, cond_z, output bo_res, bo_wr, bo_c, bo_z);
endinterface
`default_nettype wire

/* File: hw/srb_params.svh */
// Constants for the shift, rotate and bit manipulation unit.
// Assumes inclusion by bare name from the package and the design modules.
// Operation
// - Logical shifts take byte, word or longword register or memory operands, written back.
// - Logical shifts fill vacated bits with zero in both directions.
// - Fixed logical shift distances are exactly 1, 2, 4, 8 or 16.
// - Register logical shifts also take any distance from 5-bit immediate or register.
// - Arithmetic shifts act on byte, word or longword, by one or two positions.
// - Rotates with or without carry act on all sizes, by one or two positions.
// - Carry rotates feed carry into vacated end and catch the bit rotated out.
// - Bit set forces selected byte bit to one; index immediate or register low bits.
// - Conditional bit set writes memory byte only when zero flag condition holds.
// - Bit clear forces selected byte bit to zero; index immediate or register.
// - Conditional bit clear writes memory byte only when zero flag condition holds.
// - Bit invert complements selected byte bit; index immediate or register.
// - Bit test loads zero flag with inverse of selected bit, operand unchanged.
// - Carry AND replaces carry with carry AND selected bit; immediate index only.
// - Carry AND inverse replaces carry with carry AND inverted bit; immediate index.
`ifndef SRB_PARAMS_SVH
`define SRB_PARAMS_SVH

`define SRB_DATA_W      32
`define SRB_AMT_W       5
`define SRB_IDX_W       3
`define SRB_MASK_BYTE   32'h000000ff
`define SRB_MASK_WORD   32'h0000ffff
`define SRB_MASK_LONG   32'hffffffff
`define SRB_MSB_BYTE    5'h07
`define SRB_MSB_WORD    5'h0f
`define SRB_MSB_LONG    5'h1f
`define SRB_DIST_1      5'h01
`define SRB_DIST_2      5'h02
`define SRB_DIST_4      5'h04
`define SRB_DIST_8      5'h08
`define SRB_DIST_16     5'h10
`define SRB_RST_DATA    32'h00000000
`define SRB_RST_FLAG    1'h0

`endif

/* File: hw/srb_pkg.sv */
// Types shared by the shift, rotate and bit manipulation unit.
// Assumes the constants header is on the include path.
`include "srb_params.svh"
package srb_pkg;

  typedef enum logic [3:0] {
    OP_LOGICAL_LEFT_SHIFT           = 4'h0,
    OP_LOGICAL_RIGHT_SHIFT          = 4'h1,
    OP_ARITH_LEFT_SHIFT             = 4'h2,
    OP_ARITH_RIGHT_SHIFT            = 4'h3,
    OP_ROTATE_LEFT                  = 4'h4,
    OP_ROTATE_RIGHT                 = 4'h5,
    OP_ROTATE_LEFT_THROUGH_CARRY    = 4'h6,
    OP_ROTATE_RIGHT_THROUGH_CARRY   = 4'h7,
    OP_BIT_SET                      = 4'h8,
    OP_CONDITIONAL_BIT_SET          = 4'h9,
    OP_BIT_CLEAR                    = 4'ha,
    OP_CONDITIONAL_BIT_CLEAR        = 4'hb,
    OP_BIT_INVERT                   = 4'hc,
    OP_BIT_TEST                     = 4'hd,
    OP_CARRY_AND_BIT                = 4'he,
    OP_CARRY_AND_INVERSE_BIT        = 4'hf
  } srb_op_e;

  typedef enum logic [1:0] {
    SZ_BYTE = 2'h0,
    SZ_WORD = 2'h1,
    SZ_LONG = 2'h2
  } srb_size_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_DONE = 2'b10
  } srb_state_e;

  typedef logic [`SRB_DATA_W-1:0] srb_data_t;

  typedef struct packed {
    srb_state_e st;
    srb_data_t  result;
    logic       write;
    logic       c_we;
    logic       c;
    logic       z_we;
    logic       z;
    logic       n_we;
    logic       n;
    logic       illegal;
  } srb_state_s;

endpackage

/* File: hw/srb_shifter.sv */
// Shift and rotate engine, purely combinational.
// Assumes the top has already checked that the distance is legal for the operation.
`timescale 1ns/1ps
`default_nettype none
`include "srb_params.svh"
module srb_shifter (
  srb_op_if.shf bus
);
  logic [`SRB_DATA_W-1:0] mask;
  logic [`SRB_AMT_W-1:0]  msb;
  logic [`SRB_DATA_W-1:0] v;
  logic [`SRB_DATA_W-1:0] top_bit;
  logic                   c;
  logic                   out_hi;
  logic                   out_lo;

  // A fixed 32-step ladder keeps the logic static; only steps below the distance act.
  always_comb begin
    mask    = `SRB_MASK_LONG;
    msb     = `SRB_MSB_LONG;
    if (bus.size == srb_pkg::SZ_BYTE) begin
      mask = `SRB_MASK_BYTE;
      msb  = `SRB_MSB_BYTE;
    end else if (bus.size == srb_pkg::SZ_WORD) begin
      mask = `SRB_MASK_WORD;
      msb  = `SRB_MSB_WORD;
    end
    top_bit = 32'h00000001 << msb;
    v       = bus.operand & mask;
    c       = (bus.op == srb_pkg::OP_ROTATE_LEFT_THROUGH_CARRY ||
               bus.op == srb_pkg::OP_ROTATE_RIGHT_THROUGH_CARRY) ? bus.cin : 1'h0;
    out_hi  = 1'h0;
    out_lo  = 1'h0;
    for (int i = 0; i < `SRB_DATA_W; i++) begin
      if (5'(i) < bus.amt) begin
        out_hi = v[msb];
        out_lo = v[0];
        case (bus.op)
          srb_pkg::OP_LOGICAL_LEFT_SHIFT,
          srb_pkg::OP_ARITH_LEFT_SHIFT: begin
            v = (v << 1) & mask;
            c = out_hi;
          end
          srb_pkg::OP_LOGICAL_RIGHT_SHIFT: begin
            v = v >> 1;
            c = out_lo;
          end
          srb_pkg::OP_ARITH_RIGHT_SHIFT: begin
            v = (v >> 1) | (out_hi ? top_bit : 32'h00000000);
            c = out_lo;
          end
          srb_pkg::OP_ROTATE_LEFT: begin
            v = ((v << 1) & mask) | {31'h00000000, out_hi};
            c = out_hi;
          end
          srb_pkg::OP_ROTATE_RIGHT: begin
            v = (v >> 1) | (out_lo ? top_bit : 32'h00000000);
            c = out_lo;
          end
          srb_pkg::OP_ROTATE_LEFT_THROUGH_CARRY: begin
            v = ((v << 1) & mask) | {31'h00000000, c};
            c = out_hi;
          end
          srb_pkg::OP_ROTATE_RIGHT_THROUGH_CARRY: begin
            v = (v >> 1) | (c ? top_bit : 32'h00000000);
            c = out_lo;
          end
          default: begin
            v = v;
          end
        endcase
      end
    end
    bus.sh_res = v;
    bus.sh_c   = c;
  end
endmodule
`default_nettype wire

/* File: hw/srb_unit.sv */
// Top of the shift, rotate and bit manipulation unit.
// Assumes the decoder drives all inputs synchronously on I_REF_CLK and writes back results and flags.
`timescale 1ns/1ps
`default_nettype none
`include "srb_params.svh"
module srb_unit (
  input  wire logic                   I_REF_CLK,
  input  wire logic                   I_SYS_RST,
  input  wire logic                   I_START,
  input  wire logic [3:0]             I_OP,
  input  wire logic [1:0]             I_SIZE,
  input  wire logic                   I_DST_IS_MEM,
  input  wire logic [`SRB_DATA_W-1:0] I_OPERAND,
  input  wire logic                   I_AMT_ARBITRARY,
  input  wire logic                   I_AMT_FROM_REG,
  input  wire logic [`SRB_AMT_W-1:0]  I_AMT_IMM,
  input  wire logic [`SRB_DATA_W-1:0] I_AMT_REG,
  input  wire logic                   I_IDX_FROM_REG,
  input  wire logic [`SRB_IDX_W-1:0]  I_IDX_IMM,
  input  wire logic [`SRB_DATA_W-1:0] I_IDX_REG,
  input  wire logic                   I_COND_Z,
  input  wire logic                   I_FLAG_C,
  input  wire logic                   I_FLAG_Z,
  output logic                        O_DONE,
  output logic                        O_WRITE,
  output logic [`SRB_DATA_W-1:0]      O_RESULT,
  output logic                        O_C_WE,
  output logic                        O_C,
  output logic                        O_Z_WE,
  output logic                        O_Z,
  output logic                        O_N_WE,
  output logic                        O_N,
  output logic                        O_ILLEGAL
);
  srb_pkg::srb_state_s    state_q;
  srb_pkg::srb_state_s    state_d;
  srb_pkg::srb_op_e       op;
  srb_pkg::srb_size_e     size;
  logic [`SRB_AMT_W-1:0]  amt;
  logic [`SRB_DATA_W-1:0] mask;
  logic [`SRB_AMT_W-1:0]  msb;
  logic [`SRB_DATA_W-1:0] sh_masked;
  logic                   is_shift;
  logic                   is_logical;
  logic                   is_one_two;
  logic                   fixed_ok;
  logic                   size_ok;
  logic                   legal;

  srb_op_if bus ();

  srb_shifter u_shifter (
    .bus (bus.shf)
  );

  srb_bit_engine u_bit (
    .bus (bus.bit_eng)
  );

  assign op   = srb_pkg::srb_op_e'(I_OP);
  assign size = srb_pkg::srb_size_e'(I_SIZE);

  // Distance source for shifts: fixed code or arbitrary from immediate or register.
  assign amt = (I_AMT_ARBITRARY && I_AMT_FROM_REG) ? I_AMT_REG[`SRB_AMT_W-1:0] : I_AMT_IMM;

  assign bus.op      = op;
  assign bus.size    = size;
  assign bus.operand = I_OPERAND;
  assign bus.amt     = amt;
  assign bus.idx     = I_IDX_FROM_REG ? I_IDX_REG[`SRB_IDX_W-1:0] : I_IDX_IMM;
  assign bus.cin     = I_FLAG_C;
  assign bus.zin     = I_FLAG_Z;
  assign bus.cond_z  = I_COND_Z;

  always_comb begin
    mask = `SRB_MASK_LONG;
    msb  = `SRB_MSB_LONG;
    if (size == srb_pkg::SZ_BYTE) begin
      mask = `SRB_MASK_BYTE;
      msb  = `SRB_MSB_BYTE;
    end else if (size == srb_pkg::SZ_WORD) begin
      mask = `SRB_MASK_WORD;
      msb  = `SRB_MSB_WORD;
    end
  end

  assign sh_masked  = bus.sh_res & mask;
  assign is_shift   = ~I_OP[3];
  assign is_logical = (op == srb_pkg::OP_LOGICAL_LEFT_SHIFT) || (op == srb_pkg::OP_LOGICAL_RIGHT_SHIFT);
  assign is_one_two = (amt == `SRB_DIST_1) || (amt == `SRB_DIST_2);
  assign fixed_ok   = is_one_two || (amt == `SRB_DIST_4) || (amt == `SRB_DIST_8) ||
                      (amt == `SRB_DIST_16);
  assign size_ok    = (size == srb_pkg::SZ_BYTE) || (size == srb_pkg::SZ_WORD) ||
                      (size == srb_pkg::SZ_LONG);

  // Illegal requests leave operand and flags untouched; the decoder should trap on O_ILLEGAL.
  always_comb begin
    legal = 1'h1;
    if (is_shift) begin
      if (!size_ok) begin
        legal = 1'h0;
      end else if (is_logical && I_AMT_ARBITRARY) begin
        legal = ~I_DST_IS_MEM;
      end else if (is_logical) begin
        legal = fixed_ok;
      end else begin
        legal = is_one_two && !I_AMT_ARBITRARY;
      end
    end else if (op == srb_pkg::OP_CARRY_AND_BIT || op == srb_pkg::OP_CARRY_AND_INVERSE_BIT) begin
      legal = ~I_IDX_FROM_REG;
    end else if (op == srb_pkg::OP_CONDITIONAL_BIT_SET || op == srb_pkg::OP_CONDITIONAL_BIT_CLEAR) begin
      legal = I_DST_IS_MEM;
    end
  end

  always_comb begin
    state_d         = state_q;
    state_d.st      = srb_pkg::ST_IDLE;
    state_d.write   = 1'h0;
    state_d.c_we    = 1'h0;
    state_d.z_we    = 1'h0;
    state_d.n_we    = 1'h0;
    state_d.illegal = 1'h0;
    case (state_q.st)
      srb_pkg::ST_IDLE,
      srb_pkg::ST_DONE: begin
        if (I_START) begin
          state_d.st = srb_pkg::ST_DONE;
          if (!legal) begin
            state_d.illegal = 1'h1;
          end else if (is_shift) begin
            state_d.result = sh_masked;
            state_d.write  = 1'h1;
            state_d.c_we   = 1'h1;
            state_d.c      = bus.sh_c;
            state_d.z_we   = 1'h1;
            state_d.z      = (sh_masked == 32'h00000000);
            state_d.n_we   = 1'h1;
            state_d.n      = sh_masked[msb];
          end else begin
            state_d.result = {24'h000000, bus.bo_res};
            state_d.write  = bus.bo_wr;
            state_d.c_we   = (op == srb_pkg::OP_CARRY_AND_BIT) || (op == srb_pkg::OP_CARRY_AND_INVERSE_BIT);
            state_d.c      = bus.bo_c;
            state_d.z_we   = (op == srb_pkg::OP_BIT_TEST);
            state_d.z      = bus.bo_z;
          end
        end
      end
      default: begin
        state_d.st = srb_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_SYS_RST) begin
      state_q.st      <= srb_pkg::ST_IDLE;
      state_q.result  <= `SRB_RST_DATA;
      state_q.write   <= `SRB_RST_FLAG;
      state_q.c_we    <= `SRB_RST_FLAG;
      state_q.c       <= `SRB_RST_FLAG;
      state_q.z_we    <= `SRB_RST_FLAG;
      state_q.z       <= `SRB_RST_FLAG;
      state_q.n_we    <= `SRB_RST_FLAG;
      state_q.n       <= `SRB_RST_FLAG;
      state_q.illegal <= `SRB_RST_FLAG;
    end else begin
      state_q <= state_d;
    end
  end

  assign O_DONE    = (state_q.st == srb_pkg::ST_DONE);
  assign O_WRITE   = state_q.write;
  assign O_RESULT  = state_q.result;
  assign O_C_WE    = state_q.c_we;
  assign O_C       = state_q.c;
  assign O_Z_WE    = state_q.z_we;
  assign O_Z       = state_q.z;
  assign O_N_WE    = state_q.n_we;
  assign O_N       = state_q.n;
  assign O_ILLEGAL = state_q.illegal;
endmodule
`default_nettype wire

/* File: test/srb_unit_asserts.sv */
// Checker for the shift, rotate and bit unit, watching only its top ports.
// Assumes one clock domain and the synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module srb_unit_asserts (
  input wire logic        I_REF_CLK,
  input wire logic        I_SYS_RST,
  input wire logic        I_START,
  input wire logic [3:0]  I_OP,
  input wire logic [31:0] I_OPERAND,
  input wire logic        I_IDX_FROM_REG,
  input wire logic [2:0]  I_IDX_IMM,
  input wire logic [31:0] I_IDX_REG,
  input wire logic        I_FLAG_C,
  input wire logic        O_DONE,
  input wire logic        O_WRITE,
  input wire logic [31:0] O_RESULT,
  input wire logic        O_C_WE,
  input wire logic        O_C,
  input wire logic        O_Z_WE,
  input wire logic        O_Z,
  input wire logic        O_N_WE,
  input wire logic        O_ILLEGAL
);
  default clocking @(posedge I_REF_CLK); endclocking
  default disable iff (I_SYS_RST);

  // The request is captured here so bit checks see the cause of the answer.
  logic       req_q;
  logic [3:0] op_q;
  logic [7:0] b_q;
  logic [2:0] ix_q;
  logic       c_q;
  logic       fr_q;
  always_ff @(posedge I_REF_CLK) begin
    req_q <= I_START & ~I_SYS_RST;
    op_q  <= I_OP;
    b_q   <= I_OPERAND[7:0];
    ix_q  <= I_IDX_FROM_REG ? I_IDX_REG[2:0] : I_IDX_IMM;
    c_q   <= I_FLAG_C;
    fr_q  <= I_IDX_FROM_REG;
  end

  a_done_after_req: assert property (I_START |=> O_DONE)
    else $error("done missing after request");
  a_quiet_no_req: assert property (!I_START |=> !O_DONE && !O_WRITE)
    else $error("answer without request");
  a_illegal_no_write: assert property (O_ILLEGAL |-> O_DONE && !O_WRITE && !O_C_WE && !O_Z_WE && !O_N_WE)
    else $error("refused request wrote something");
  a_bit_test_z: assert property (req_q && op_q == 4'hd |-> O_Z_WE && !O_WRITE && O_Z == !b_q[ix_q])
    else $error("bit test zero flag wrong");
  a_carry_and_bit: assert property (req_q && op_q == 4'he && !fr_q |-> O_C_WE && O_C == (c_q & b_q[ix_q]))
    else $error("carry and wrong");
  a_carry_and_inv: assert property (req_q && op_q == 4'hf && !fr_q |-> O_C_WE && O_C == (c_q & !b_q[ix_q]))
    else $error("carry and inverse wrong");
  a_bit_set_val: assert property (req_q && op_q == 4'h8 |-> O_WRITE && O_RESULT == {24'h0, b_q | (8'h01 << ix_q)})
    else $error("bit set result wrong");
  a_bit_clear_val: assert property (req_q && op_q == 4'ha |-> O_WRITE && O_RESULT == {24'h0, b_q & ~(8'h01 << ix_q)})
    else $error("bit clear result wrong");
  a_bit_invert_val: assert property (req_q && op_q == 4'hc |-> O_WRITE && O_RESULT == {24'h0, b_q ^ (8'h01 << ix_q)})
    else $error("bit invert result wrong");
endmodule
`default_nettype wire

/* File: test/srb_wb_model.sv */
// Write-back side of the decoder and register file: holds the last written operand.
// Assumes the unit's write pulse lasts one cycle on the same clock.
`timescale 1ns/1ps
`default_nettype none
module srb_wb_model (
  input  wire logic        i_clk,
  input  wire logic        i_wr,
  input  wire logic [31:0] i_res,
  output logic [31:0]      o_val
);
  // Only written operands change, so a missing write shows as a stale value.
  always_ff @(posedge i_clk) begin
    if (i_wr) begin
      o_val <= i_res;
    end
  end
endmodule
`default_nettype wire

/* File: test/tb_top.sv */
// Self-checking bench for the shift, rotate and bit unit.
// Assumes the checker and write-back model files are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        st = 1'b0;
  logic        mem = 1'b0, arb = 1'b0, amt_reg = 1'b0, idx_reg = 1'b0, cz = 1'b0, fc = 1'b0, fz = 1'b0;
  logic [3:0]  op = 4'h0;
  logic [1:0]  sz = 2'h0;
  logic [31:0] opd = 32'h0, rv = 32'h0;
  logic [4:0]  amt = 5'h0;
  logic [2:0]  idx = 3'h0;
  logic        done, wr, cwe, c, zwe, z, nwe, n, ill;
  logic [31:0] res, wb_val;
  int          n_mismatch = 0;
  int          samples_checked = 0;

  srb_unit srb_unit_i (.I_REF_CLK(clk), .I_SYS_RST(rst), .I_START(st), .I_OP(op), .I_SIZE(sz),
    .I_DST_IS_MEM(mem), .I_OPERAND(opd), .I_AMT_ARBITRARY(arb), .I_AMT_FROM_REG(amt_reg), .I_AMT_IMM(amt),
    .I_AMT_REG(rv), .I_IDX_FROM_REG(idx_reg), .I_IDX_IMM(idx), .I_IDX_REG(rv), .I_COND_Z(cz), .I_FLAG_C(fc),
    .I_FLAG_Z(fz), .O_DONE(done), .O_WRITE(wr), .O_RESULT(res), .O_C_WE(cwe), .O_C(c), .O_Z_WE(zwe),
    .O_Z(z), .O_N_WE(nwe), .O_N(n), .O_ILLEGAL(ill));
  srb_wb_model srb_wb_model_i (.i_clk(clk), .i_wr(wr), .i_res(res), .o_val(wb_val));

  initial begin
    forever #5 clk = ~clk;
  end

  task automatic print_verdict();
    $display("mismatches %0d comparisons %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk1(input string nm, input logic e, input logic g);
    chk32(nm, {31'h0, e}, {31'h0, g});
  endtask

  // Reference shifter: returns last bit out above the size-masked result.
  function automatic logic [32:0] ref_sh(input logic [3:0] o, input logic [1:0] s, input logic [31:0] v,
                                         input logic [4:0] d, input logic ci);
    logic [31:0] r, mk;
    int          m;
    logic        t;
    m = (8 << s) - 1;
    mk = (s == 2'h2) ? 32'hffffffff : ((32'h1 << (m + 1)) - 32'h1);
    r = v & mk;
    t = 1'b0;
    for (int i = 0; i < d; i++) begin
      case (o)
        4'h0, 4'h2: begin t = r[m]; r = r << 1; end
        4'h1: begin t = r[0]; r = r >> 1; end
        4'h3: begin t = r[0]; r = (r >> 1) | ({31'h0, r[m]} << m); end
        4'h4: begin t = r[m]; r = (r << 1) | {31'h0, t}; end
        4'h5: begin t = r[0]; r = (r >> 1) | ({31'h0, t} << m); end
        4'h6: begin t = r[m]; r = (r << 1) | {31'h0, ci}; ci = t; end
        default: begin t = r[0]; r = (r >> 1) | ({31'h0, ci} << m); ci = t; end
      endcase
      r = r & mk;
    end
    return {t, r};
  endfunction

  // Flags m: mem, arbitrary, distance from register, index from register, cond, carry, zero.
  task automatic issue(input logic [3:0] o, input logic [1:0] s, input logic [31:0] v, input logic [4:0] a,
                       input logic [2:0] x, input logic [31:0] r, input logic [6:0] m);
    int k;
    @(posedge clk);
    st <= 1'b1;
    op <= o;
    sz <= s;
    opd <= v;
    amt <= a;
    idx <= x;
    rv <= r;
    {mem, arb, amt_reg, idx_reg, cz, fc, fz} <= m;
    @(posedge clk);
    st <= 1'b0;
    k = 0;
    #1;
    while (done !== 1'b1 && k < 4) begin
      @(posedge clk);
      #1;
      k++;
    end
    if (k == 4) begin
      n_mismatch++;
      print_verdict();
    end
  endtask

  task automatic s_shift_table();
    logic [4:0]  ds[5] = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h10};
    logic [32:0] e;
    logic [31:0] v;
    int          m;
    for (int o = 0; o < 8; o++) begin
      for (int s = 0; s < 3; s++) begin
        for (int j = 0; j < ((o < 2) ? 5 : 2); j++) begin
          v = 32'h9c3a5e81 ^ 32'(o * 17 + s * 5);
          m = (8 << s) - 1;
          e = ref_sh(4'(o), 2'(s), v, ds[j], j[0]);
          issue(4'(o), 2'(s), v, ds[j], 3'h0, 32'h0, {j[0], 4'h0, j[0], 1'b0});
          chk32("shift_result", e[31:0], res);
          chk1("shift_carry", e[32], c);
          chk1("shift_zero", e[31:0] == 32'h0, z);
          chk1("shift_neg", e[m], n);
          chk1("shift_flag_we", 1'b1, cwe & zwe & nwe);
          @(posedge clk);
          #1;
          chk32("writeback", e[31:0], wb_val);
        end
      end
    end
  endtask

  task automatic s_arbitrary();
    logic [32:0] e;
    e = ref_sh(4'h0, 2'h2, 32'hc0de1234, 5'h0d, 1'b0);
    issue(4'h0, 2'h2, 32'hc0de1234, 5'h0d, 3'h0, 32'h0, 7'h20);
    chk32("arb_imm", e[31:0], res);
    chk1("arb_carry", e[32], c);
    e = ref_sh(4'h1, 2'h1, 32'hc0de1234, 5'h0b, 1'b0);
    issue(4'h1, 2'h1, 32'hc0de1234, 5'h03, 3'h0, 32'hffffffeb, 7'h30);
    chk32("arb_reg", e[31:0], res);
    issue(4'h0, 2'h2, 32'hc0de1234, 5'h03, 3'h0, 32'h0, 7'h60);
    chk1("arb_mem", 1'b1, ill);
  endtask

  task automatic s_illegal();
    logic [3:0] ol[5] = '{4'h0, 4'h3, 4'h4, 4'he, 4'h9};
    logic [1:0] sl[5] = '{2'h2, 2'h0, 2'h3, 2'h0, 2'h0};
    logic [4:0] al[5] = '{5'h03, 5'h04, 5'h01, 5'h01, 5'h01};
    logic [6:0] ml[5] = '{7'h00, 7'h00, 7'h00, 7'h08, 7'h00};
    for (int i = 0; i < 5; i++) begin
      issue(ol[i], sl[i], 32'h5a, al[i], 3'h1, 32'h0, ml[i]);
      chk1("illegal", 1'b1, ill);
      chk1("illegal_write", 1'b0, wr);
    end
  endtask

  task automatic s_bitops();
    logic [3:0] ol[6] = '{4'h8, 4'ha, 4'hc, 4'hd, 4'he, 4'hf};
    logic [7:0] b, k;
    logic       r;
    for (int x = 0; x < 8; x++) begin
      for (int j = 0; j < 6; j++) begin
        b = 8'h5c + 8'(x * 29);
        k = 8'h01 << x;
        r = x[0] & (j < 4);
        issue(ol[j], 2'h2, {24'h123456, b}, 5'h01, r ? 3'(~x) : 3'(x), {29'h15a5a5a5, 3'(x)},
              {x[1], 2'b00, r, 3'b010});
        case (j)
          0: chk32("set", {24'h0, b | k}, res);
          1: chk32("clear", {24'h0, b & ~k}, res);
          2: chk32("invert", {24'h0, b ^ k}, res);
          3: chk1("test_z", ~b[x], z);
          4: chk1("and_c", b[x], c);
          default: chk1("andinv_c", ~b[x], c);
        endcase
        chk1("bit_write", j < 3, wr);
        chk1("bit_z_we", j == 3, zwe);
        chk1("bit_c_we", j > 3, cwe);
      end
    end
  endtask

  task automatic s_cond();
    logic [7:0] e;
    logic       hit;
    for (int t = 0; t < 8; t++) begin
      hit = (t[1] == t[0]);
      e = !hit ? 8'h3c : (t[2] ? 8'h38 : 8'h3e);
      issue(t[2] ? 4'hb : 4'h9, 2'h0, 32'h3c, 5'h01, t[2] ? 3'h2 : 3'h1, 32'h0, {4'h8, t[1], 1'b0, t[0]});
      chk1("cond_write", hit, wr);
      chk32("cond_result", {24'h0, e}, res);
    end
  endtask

  task automatic s_back2back();
    @(posedge clk);
    st <= 1'b1;
    op <= 4'h0;
    sz <= 2'h0;
    opd <= 32'h81;
    amt <= 5'h01;
    idx <= 3'h6;
    {mem, arb, amt_reg, idx_reg, cz, fc, fz} <= 7'h00;
    @(posedge clk);
    op <= 4'h8;
    #1;
    chk32("b2b_first", 32'h02, res);
    chk1("b2b_carry", 1'b1, c);
    @(posedge clk);
    st <= 1'b0;
    #1;
    chk1("b2b_done", 1'b1, done);
    chk32("b2b_second", 32'hc1, res);
    chk1("b2b_no_carry_we", 1'b0, cwe);
    @(posedge clk);
    #1;
    chk1("b2b_done_low", 1'b0, done);
  endtask

  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    s_shift_table();
    s_arbitrary();
    s_illegal();
    s_bitops();
    s_cond();
    s_back2back();
    print_verdict();
  end
endmodule

bind srb_unit srb_unit_asserts srb_unit_asserts_i (.I_REF_CLK, .I_SYS_RST, .I_START, .I_OP, .I_OPERAND,
  .I_IDX_FROM_REG, .I_IDX_IMM, .I_IDX_REG, .I_FLAG_C, .O_DONE, .O_WRITE, .O_RESULT, .O_C_WE, .O_C,
  .O_Z_WE, .O_Z, .O_N_WE, .O_ILLEGAL);
`default_nettype wire
